// ---- shared/lusf_map.vh ----
// Purpose: Register offsets, bit positions and reset values of the line
//          unit status and change-flag block.
// Assumes: Byte addresses on a plain 12-bit register port.
// Notes:   Definitions only.
`ifndef LUSF_MAP_VH
`define LUSF_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LUSF_ADDR_W 12
`define LUSF_OFS_IRQ_ENABLE 12'hf04
`define LUSF_OFS_LIVE_STATUS 12'hf05
`define LUSF_OFS_CHANGE_FLAGS 12'hf06
`define LUSF_OFS_CTRL 12'hf10
`define LUSF_OFS_IRQ_STATUS 12'hf11
`define LUSF_OFS_IRQ_MASK 12'hf12

// ----------------------------------------------------------------------
// Bit positions (shared by live status and change flags; single rail is a ctrl bit)
// ----------------------------------------------------------------------
`define LUSF_BIT_PATTERN 0
`define LUSF_BIT_SIGLOSS 1
`define LUSF_BIT_AIS 2
`define LUSF_BIT_LOOP 3
`define LUSF_BIT_VIOL 4
`define LUSF_BIT_FIFO 5
`define LUSF_BIT_DRIVE 6
`define LUSF_BIT_RSVD 7
`define LUSF_BIT_SINGLE_RAIL 0

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define LUSF_RST_BYTE 8'h00
`define LUSF_RST_CTRL 8'h01
`define LUSF_FLAG_MASK 8'h7f
`define LUSF_ENABLE_MASK 8'h03
`define LUSF_IRQ_SRC_MASK 8'h03

`endif

// ---- hw/lusf_edge.v ----
// Purpose: Registers a group of status levels and reports any change.
// Assumes: Inputs synchronous to i_clock.
// Notes:   o_change is a one-cycle pulse per bit.
`timescale 1ns/1ps

module lusf_edge #(
    parameter WIDTH = 8
) (
    input wire i_clock,
    input wire i_reset,
    input wire [WIDTH-1:0] i_level,
    output reg [WIDTH-1:0] o_level,
    output wire [WIDTH-1:0] o_change
);

// ----------------------------------------------------------------------
// Level capture
// ----------------------------------------------------------------------

// Holds the previous level so each transition is seen once
always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
        o_level <= {WIDTH{1'b0}};
    end else begin
        o_level <= i_level;
    end
end

// Either direction counts as a change
assign o_change = o_level ^ i_level;

endmodule // lusf_edge

// ---- hw/lusf_flags.v ----
// Purpose: Sticky flags set by hardware, cleared by a clear vector.
// Assumes: Set and clear may arrive in the same cycle.
// Notes:   Set wins over clear so no event is lost.
`timescale 1ns/1ps

module lusf_flags #(
    parameter WIDTH = 8
) (
    input wire i_clock,
    input wire i_reset,
    input wire [WIDTH-1:0] i_set,
    input wire [WIDTH-1:0] i_clear,
    output reg [WIDTH-1:0] o_flags
);

// ----------------------------------------------------------------------
// Sticky storage
// ----------------------------------------------------------------------

// Clear first, then set, giving set priority
always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
        o_flags <= {WIDTH{1'b0}};
    end else begin
        o_flags <= (o_flags & ~i_clear) | i_set;
    end
end

endmodule // lusf_flags

// ---- hw/lusf_top.v ----
// Purpose: Per-channel line unit live status, reset-on-read change flags
//          and interrupt output.
// Assumes: Status inputs synchronous to i_clock; one channel instance.
// Notes:   Read data appear the cycle after the read strobe, only then.
//          Change flags see every edge of every status bit in single rail mode; the
//          enables only decide which edges reach the interrupt.
`timescale 1ns/1ps
`include "lusf_map.vh"

// Function
// - Signal loss bit reflects live defect
// - Signal loss change interrupts when enabled
// - Pattern lock bit reflects live lock
// - Pattern lock change interrupts when enabled
// - Flags work only in single rail mode
// - Change flags clear on register read
// - Drive monitor change sets bit six
// - FIFO limit change sets bit five
// - Line violation change sets bit four
// - Loop code change sets bit three
module lusf_top (
    input wire i_clock,
    input wire i_reset,
    input wire [11:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_write,
    input wire i_read,
    input wire i_rx_signal_loss_status,
    input wire i_pattern_lock_status,
    input wire i_ais_status,
    input wire i_loop_code_detect_status,
    input wire i_line_violation_status,
    input wire i_fifo_limit_status,
    input wire i_drive_monitor_status,
    output reg [7:0] o_rdata,
    output reg o_irq
);

// ----------------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------------
reg [7:0] irq_enable;
reg [7:0] irq_mask;
reg [7:0] ctrl;
wire [7:0] raw_status;
wire [7:0] live_status;
wire [7:0] status_change;
wire [7:0] change_flags;
wire [7:0] irq_status;
wire [7:0] flag_set;
wire [7:0] flag_clear;
wire [7:0] irq_set;
wire [7:0] irq_clear;
wire single_rail;
reg [7:0] next_rdata;
wire rx_signal_loss_status;
wire pattern_lock_status;
wire ais_status;
wire loop_code_detect_status;
wire line_violation_status;
wire fifo_limit_status;
wire drive_monitor_status;
wire pattern_lock_change_flag;
wire signal_loss_change_flag;
wire ais_change_flag;
wire loop_code_change_flag;
wire line_violation_change_flag;
wire fifo_limit_change_flag;
wire drive_monitor_change_flag;
wire signal_loss_irq_enable;
wire pattern_lock_irq_enable;
wire [7:0] live_view;
wire [7:0] flag_view;

// Exact byte-address hit for a given offset
function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
        hit = (addr == ofs);
    end
endfunction

// Places the seven event bits at their register positions. One packer
// serves pins, live view and flag view, so the layouts cannot drift.
function [7:0] pack_bits;
    input pattern;
    input sigloss;
    input ais;
    input loop;
    input viol;
    input fifo;
    input drive;
    begin
        pack_bits = `LUSF_RST_BYTE;
        pack_bits[`LUSF_BIT_PATTERN] = pattern;
        pack_bits[`LUSF_BIT_SIGLOSS] = sigloss;
        pack_bits[`LUSF_BIT_AIS] = ais;
        pack_bits[`LUSF_BIT_LOOP] = loop;
        pack_bits[`LUSF_BIT_VIOL] = viol;
        pack_bits[`LUSF_BIT_FIFO] = fifo;
        pack_bits[`LUSF_BIT_DRIVE] = drive;
    end
endfunction

// ----------------------------------------------------------------------
// Status capture
// ----------------------------------------------------------------------

// Bit 7 tied low so it never reports or flags anything
// Pins are taken as synchronous already; no extra stage is spent here
assign raw_status = pack_bits(i_pattern_lock_status,
                              i_rx_signal_loss_status,
                              i_ais_status,
                              i_loop_code_detect_status,
                              i_line_violation_status,
                              i_fifo_limit_status,
                              i_drive_monitor_status);

lusf_edge #(
    .WIDTH(8)
) u_edge (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_level(raw_status),
    .o_level(live_status),
    .o_change(status_change)
);

// ----------------------------------------------------------------------
// Named bit views
// ----------------------------------------------------------------------

// Registered levels; software sees the pins one cycle late, which is
// also the instant the change flag for that edge is set
assign pattern_lock_status = live_status[`LUSF_BIT_PATTERN];
assign rx_signal_loss_status = live_status[`LUSF_BIT_SIGLOSS];
assign ais_status = live_status[`LUSF_BIT_AIS];
assign loop_code_detect_status = live_status[`LUSF_BIT_LOOP];
assign line_violation_status = live_status[`LUSF_BIT_VIOL];
assign fifo_limit_status = live_status[`LUSF_BIT_FIFO];
assign drive_monitor_status = live_status[`LUSF_BIT_DRIVE];

assign live_view = pack_bits(pattern_lock_status,
                             rx_signal_loss_status,
                             ais_status,
                             loop_code_detect_status,
                             line_violation_status,
                             fifo_limit_status,
                             drive_monitor_status);

// ----------------------------------------------------------------------
// Change flags
// ----------------------------------------------------------------------

assign single_rail = ctrl[`LUSF_BIT_SINGLE_RAIL];

assign flag_set = single_rail ?
                  (status_change & `LUSF_FLAG_MASK) | 
                  (status_change & `LUSF_IRQ_SRC_MASK) :
                  `LUSF_RST_BYTE;

assign flag_clear = (i_read && hit(i_addr, `LUSF_OFS_CHANGE_FLAGS)) ?
                    8'hff : `LUSF_RST_BYTE;

lusf_flags #(
    .WIDTH(8)
) u_change (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_set(flag_set),
    .i_clear(flag_clear),
    .o_flags(change_flags)
);

// reserved bit reads zero
// Rebuilt from the named flags, so bit 7 reads zero whatever is stored
assign pattern_lock_change_flag = change_flags[`LUSF_BIT_PATTERN];
assign signal_loss_change_flag = change_flags[`LUSF_BIT_SIGLOSS];
assign ais_change_flag = change_flags[`LUSF_BIT_AIS];
assign loop_code_change_flag = change_flags[`LUSF_BIT_LOOP];
assign line_violation_change_flag = change_flags[`LUSF_BIT_VIOL];
assign fifo_limit_change_flag = change_flags[`LUSF_BIT_FIFO];
assign drive_monitor_change_flag = change_flags[`LUSF_BIT_DRIVE];
assign flag_view = pack_bits(pattern_lock_change_flag,
                             signal_loss_change_flag,
                             ais_change_flag,
                             loop_code_change_flag,
                             line_violation_change_flag,
                             fifo_limit_change_flag,
                             drive_monitor_change_flag);

// ----------------------------------------------------------------------
// Interrupt status
// ----------------------------------------------------------------------

// Named enable bits; the other enable bits never store
assign signal_loss_irq_enable = irq_enable[`LUSF_BIT_SIGLOSS];
assign pattern_lock_irq_enable = irq_enable[`LUSF_BIT_PATTERN];

// pattern lock event
// Only the two live-status sources may raise the interrupt; flags of
// the other sources are polled by software
assign irq_set = pack_bits(flag_set[`LUSF_BIT_PATTERN] &
                           pattern_lock_irq_enable,
                           flag_set[`LUSF_BIT_SIGLOSS] &
                           signal_loss_irq_enable,
                           1'b0,
                           1'b0,
                           1'b0,
                           1'b0,
                           1'b0);

// Write one to clear
assign irq_clear = (i_write && hit(i_addr, `LUSF_OFS_IRQ_STATUS)) ?
                   i_wdata : `LUSF_RST_BYTE;

lusf_flags #(
    .WIDTH(8)
) u_irq (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_set(irq_set),
    .i_clear(irq_clear),
    .o_flags(irq_status)
);

// ----------------------------------------------------------------------
// Writable registers
// ----------------------------------------------------------------------

// Only implemented bits store; the rest read zero
always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
        irq_enable <= `LUSF_RST_BYTE;
        irq_mask <= `LUSF_RST_BYTE;
        ctrl <= `LUSF_RST_CTRL;
    end else if (i_write) begin
        if (hit(i_addr, `LUSF_OFS_IRQ_ENABLE)) begin
            irq_enable <= i_wdata & `LUSF_ENABLE_MASK;
        end
        if (hit(i_addr, `LUSF_OFS_IRQ_MASK)) begin
            irq_mask <= i_wdata & `LUSF_IRQ_SRC_MASK;
        end
        if (hit(i_addr, `LUSF_OFS_CTRL)) begin
            ctrl <= i_wdata & `LUSF_RST_CTRL;
        end
    end
end

// ----------------------------------------------------------------------
// Read path
// ----------------------------------------------------------------------

// Unmapped offsets and idle cycles give zero, so no answer lingers
// live signal loss
always @* begin
    next_rdata = `LUSF_RST_BYTE;
    if (i_read) begin
        case (i_addr)
            `LUSF_OFS_IRQ_ENABLE: next_rdata = irq_enable;
            `LUSF_OFS_LIVE_STATUS: next_rdata = live_view;
            `LUSF_OFS_CHANGE_FLAGS: next_rdata = flag_view;
            `LUSF_OFS_CTRL: next_rdata = ctrl;
            `LUSF_OFS_IRQ_STATUS: next_rdata = irq_status;
            `LUSF_OFS_IRQ_MASK: next_rdata = irq_mask;
            default: next_rdata = `LUSF_RST_BYTE;
        endcase
    end
end

// Data stand one cycle only, zero otherwise
always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
        o_rdata <= `LUSF_RST_BYTE;
    end else begin
        o_rdata <= next_rdata;
    end
end

// Level interrupt; one cycle behind status by design
always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
        o_irq <= 1'b0;
    end else begin
        o_irq <= |(irq_status & irq_mask);
    end
end

endmodule // lusf_top

// ---- tb/lusf_properties.sv ----
// Purpose: Port-level checks of the line unit status flag block.
// Assumes: Single rail mode is on whenever a change is read back.
// Notes:   Read data stand only in the cycle after the strobe.
`timescale 1ns/1ps
`include "lusf_map.vh"

module lusf_properties (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic i_rx_signal_loss_status,
    input wire logic i_pattern_lock_status,
    input wire logic i_ais_status,
    input wire logic i_loop_code_detect_status,
    input wire logic i_line_violation_status,
    input wire logic i_fifo_limit_status,
    input wire logic i_drive_monitor_status,
    input wire logic [7:0] o_rdata,
    input wire logic o_irq
);
    // Status levels gathered in change-flag bit order
    wire [6:0] st = {i_drive_monitor_status, i_fifo_limit_status,
        i_line_violation_status, i_loop_code_detect_status,
        i_ais_status, i_rx_signal_loss_status, i_pattern_lock_status};
    wire rd_flags = i_read && (i_addr == `LUSF_OFS_CHANGE_FLAGS);
    wire rd_live = i_read && (i_addr == `LUSF_OFS_LIVE_STATUS);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    // A change seen one edge before a flag read must show up in it
    property flag_p(b);
        $changed(st[b]) ##1 rd_flags |=> o_rdata[b];
    endproperty

    // Bus answers only in the cycle after a read
    idle_rdata_a: assert property (!i_read |=> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    reserved_bit_a: assert property (i_read |=> !o_rdata[7])
        else $error("reserved bit seven read as one");
    sigloss_live_a: assert property (rd_live |=>
        o_rdata[1] == $past(i_rx_signal_loss_status, 2))
        else $error("signal loss status bit wrong");
    pattern_live_a: assert property (rd_live |=>
        o_rdata[0] == $past(i_pattern_lock_status, 2))
        else $error("pattern lock status bit wrong");
    flag_clear_a: assert property (rd_flags && $stable(st) ##1
        $stable(st) ##1 rd_flags |=> o_rdata == 8'h00)
        else $error("change flags not cleared by read");
    drive_flag_a: assert property (flag_p(6))
        else $error("drive monitor flag missing");
    fifo_flag_a: assert property (flag_p(5))
        else $error("fifo limit flag missing");
    viol_flag_a: assert property (flag_p(4))
        else $error("line violation flag missing");
    loop_flag_a: assert property (flag_p(3))
        else $error("loop code flag missing");

    // Main scenarios reached
    cover property (rd_flags ##1 o_rdata != 8'h00);
    cover property ($rose(o_irq));
    cover property (rd_flags && $changed(st));
endmodule // lusf_properties

// ---- tb/test_lusf_top.sv ----
// Purpose: Self-checking register bench of the line unit flag block.
// Assumes: Status vector s is kept in change-flag bit order.
// Notes:   Every wait is bounded and ends in give_verdict on expiry.
`timescale 1ns/1ps
`include "lusf_map.vh"

module test_lusf_top;
    reg i_clock = 1'b0;
    reg i_reset = 1'b1;
    reg [11:0] i_addr = 12'h000;
    reg [7:0] i_wdata = 8'h00;
    reg i_write = 1'b0;
    reg i_read = 1'b0;
    reg [6:0] s = 7'h00;
    reg [6:0] pat = 7'h00;
    wire [7:0] o_rdata;
    wire o_irq;
    integer miscompares = 0;
    integer n_checks = 0;
    integer k;
    integer j;

    // 250 MHz clock
    always #2 i_clock = ~i_clock;

    lusf_top dut_u (.i_clock(i_clock), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .i_rx_signal_loss_status(s[1]),
        .i_pattern_lock_status(s[0]), .i_ais_status(s[2]),
        .i_loop_code_detect_status(s[3]),
        .i_line_violation_status(s[4]), .i_fifo_limit_status(s[5]),
        .i_drive_monitor_status(s[6]), .o_rdata(o_rdata), .o_irq(o_irq));

    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Read strobe for one cycle; new status lands on the same edge
    task rd(input [11:0] a, input [6:0] ns, input [7:0] exp);
        begin
            @(posedge i_clock);
            i_read <= 1'b1;
            i_addr <= a;
            s <= ns;
            @(posedge i_clock);
            i_read <= 1'b0;
            #1 chk(o_rdata, exp);
        end
    endtask

    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge i_clock);
            i_write <= 1'b1;
            i_addr <= a;
            i_wdata <= d;
            @(posedge i_clock);
            i_write <= 1'b0;
        end
    endtask

    task st(input [6:0] ns);
        begin
            @(posedge i_clock);
            s <= ns;
        end
    endtask

    task give_verdict;
        begin
            $display("checks=%0d miscompares=%0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // Bounded wait for the interrupt level
    task wait_irq(input exp);
        begin
            k = 0;
            while (o_irq !== exp && k < 8) begin
                @(posedge i_clock);
                #1 k = k + 1;
            end
            chk({7'h00, o_irq}, {7'h00, exp});
            if (o_irq !== exp)
                give_verdict;
        end
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(12'hf04, 7'h00, 8'h00);
        rd(12'hf10, 7'h00, 8'h01);
        rd(12'hf12, 7'h00, 8'h00);
        rd(12'h000, 7'h00, 8'h00);
        wr(12'hf06, 8'hff);
        wr(12'hf05, 8'hff);
        rd(12'hf06, 7'h00, 8'h00);
        st(7'h03);
        rd(12'hf05, 7'h03, 8'h03);
        rd(12'hf06, 7'h03, 8'h03);
        rd(12'hf06, 7'h03, 8'h00);
        // Both edges of every remaining status bit
        // framer bypassed, violation flag polled
        for (j = 2; j < 7; j = j + 1) begin
            pat = 7'h03 | (7'h01 << j);
            st(pat);
            rd(12'hf06, pat, 8'h01 << j);
            st(7'h03);
            rd(12'hf06, 7'h03, 8'h01 << j);
        end
        // Change on the very edge of a read is kept for the next read
        rd(12'hf06, 7'h13, 8'h00);
        rd(12'hf06, 7'h13, 8'h10);
        rd(12'hf06, 7'h03, 8'h00);
        rd(12'hf06, 7'h03, 8'h10);
        wr(12'hf04, 8'h03);
        wr(12'hf12, 8'h03);
        st(7'h02);
        wait_irq(1'b1);
        rd(12'hf11, 7'h02, 8'h01);
        wr(12'hf11, 8'h01);
        wait_irq(1'b0);
        // Masked source holds status but not the output
        wr(12'hf12, 8'h01);
        st(7'h00);
        repeat (3) @(posedge i_clock);
        wait_irq(1'b0);
        rd(12'hf11, 7'h00, 8'h02);
        wr(12'hf12, 8'h03);
        wait_irq(1'b1);
        wr(12'hf11, 8'h02);
        wait_irq(1'b0);
        rd(12'hf06, 7'h00, 8'h03);
        // Rising edge of signal loss interrupts as well
        st(7'h02);
        wait_irq(1'b1);
        wr(12'hf11, 8'h02);
        wait_irq(1'b0);
        rd(12'hf06, 7'h02, 8'h02);
        // Single rail off: no flags, live status still reads
        wr(12'hf10, 8'h00);
        st(7'h40);
        repeat (2) @(posedge i_clock);
        rd(12'hf06, 7'h40, 8'h00);
        rd(12'hf05, 7'h40, 8'h40);
        wr(12'hf10, 8'h01);
        give_verdict;
    end
endmodule // test_lusf_top

bind lusf_top lusf_properties chk_u (.i_clock(i_clock), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
    .i_read(i_read), .i_rx_signal_loss_status(i_rx_signal_loss_status),
    .i_pattern_lock_status(i_pattern_lock_status),
    .i_ais_status(i_ais_status),
    .i_loop_code_detect_status(i_loop_code_detect_status),
    .i_line_violation_status(i_line_violation_status),
    .i_fifo_limit_status(i_fifo_limit_status),
    .i_drive_monitor_status(i_drive_monitor_status),
    .o_rdata(o_rdata), .o_irq(o_irq));
